// ---- verilog/mfps_top.sv ----
/*
  Motor fault protection sequencer: fault gating of the bridge outputs,
  locked-rotor detect and release, start-up mode, Avalon-MM registers and
  interrupt. Assumes comparator flags and sensor pins asynchronous, normal
  drive pattern from a PWM generator on the same clock.
*/
// Contract
// - Declare locked rotor when sensor period reaches half a second.
// - Cancel lock five seconds after speed command leaves standby.
// - Release lock after five consecutive sensor cycles at 2 Hz or faster.
// - Release lock on sleep-to-active transition or power reapplied.
// - Locked rotor: high sides off, low sides on.
// - Overvoltage flag set: high sides off, low sides on.
// - Overcurrent: high sides off, low sides on, release when it clears.
// - Over-temperature flag: all phase switches off until released.
// - Drive pattern uses duration of previous sensor cycle.
// - Re-enter start-up after sleep wake, or standby command once stopped.
`timescale 1ns/1ps
`default_nettype none
module mfps_top import mfps_pkg::*; #(
  parameter int unsigned LOCK_CYCLES = LOCK_CYC,
  parameter int unsigned AUTO_CYCLES = AUTO_CYC
) (
  input wire logic clk_sys_in,
  input wire logic sys_rst_in,
  input wire logic hall_in,
  input wire logic sleep_active_in,
  input wire logic speed_command_standby_in,
  input wire logic undervoltage_lockout_in,
  input wire logic overvoltage_lockout_in,
  input wire logic current_sense_in,
  input wire logic over_temp_in,
  input wire logic [2:0] drive_hs_in,
  input wire logic [2:0] drive_ls_in,
  input wire logic [7:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic [3:0] avs_byteenable_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  output logic [2:0] hs_on_out,
  output logic [2:0] ls_on_out,
  output logic lock_out,
  output logic startup_mode_out,
  output logic [PERIOD_W-1:0] energize_period_out,
  output logic irq_out
);
  localparam logic [31:0] AUTO_LIM = 32'(AUTO_CYCLES);

  mfps_pins_t pins_raw, pins;
  logic [PIN_W-1:0] pins_sync;
  logic hall_edge, hall_fast, stalled;
  logic [PERIOD_W-1:0] meas_period;

  assign pins_raw = '{hall: hall_in, sleep_active: sleep_active_in,
    standby: speed_command_standby_in,
    flt: '{uv: undervoltage_lockout_in, ov: overvoltage_lockout_in,
           oc: current_sense_in, ot: over_temp_in}};
  assign pins = mfps_pins_t'(pins_sync);

  mfps_sync #(.W(PIN_W)) u_sync (
    .clk_sys_in(clk_sys_in),
    .sys_rst_in(sys_rst_in),
    .sig_in(pins_raw),
    .sig_out(pins_sync)
  );

  mfps_period_timer #(.LIMIT(LOCK_CYCLES)) u_timer (
    .clk_sys_in(clk_sys_in),
    .sys_rst_in(sys_rst_in),
    .hall_in(pins.hall),
    .edge_out(hall_edge),
    .fast_out(hall_fast),
    .stalled_out(stalled),
    .period_out(meas_period)
  );

  // Sleep wake edge and fault edge detection
  logic sleep_prev_q, sleep_prev_d;
  mfps_fault_t flt_prev_q, flt_prev_d;
  logic sleep_rise;

  assign sleep_rise = pins.sleep_active & ~sleep_prev_q;

  always_comb begin
    sleep_prev_d = pins.sleep_active;
    flt_prev_d = pins.flt;
  end

  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      sleep_prev_q <= 1'b0;
      flt_prev_q <= '0;
    end else begin
      sleep_prev_q <= sleep_prev_d;
      flt_prev_q <= flt_prev_d;
    end
  end

  // Locked-rotor sequencer
  logic lock_q, lock_d;
  logic startup_q, startup_d;
  logic [2:0] fast_cnt_q, fast_cnt_d;
  logic [31:0] auto_cnt_q, auto_cnt_d;
  logic can_lock, fast_release, auto_release, lock_set, lock_clr;

  assign can_lock = pins.sleep_active & ~pins.standby;
  assign fast_release = hall_fast & (fast_cnt_q == FAST_CYCLES - 3'h1);
  assign auto_release = ~pins.standby & (auto_cnt_q == AUTO_LIM - 32'h1);
  assign lock_clr = lock_q & (fast_release | auto_release | sleep_rise);
  assign lock_set = ~lock_q & stalled & can_lock & ~sleep_rise;

  always_comb begin
    lock_d = lock_q;
    startup_d = startup_q;
    fast_cnt_d = fast_cnt_q;
    auto_cnt_d = auto_cnt_q;
    if (stalled || (hall_edge && !hall_fast)) begin
      fast_cnt_d = 3'h0;
    end else if (hall_fast) begin
      fast_cnt_d = fast_release ? 3'h0 : fast_cnt_q + 3'h1;
    end
    if (lock_set) begin
      lock_d = 1'b1;
    end else if (lock_clr) begin
      lock_d = 1'b0;
    end
    if (!lock_q || pins.standby || auto_release) begin
      auto_cnt_d = 32'h0;
    end else begin
      auto_cnt_d = auto_cnt_q + 32'h1;
    end
    if (sleep_rise || (pins.standby && stalled)) begin
      startup_d = 1'b1;
    end else if (fast_release) begin
      startup_d = 1'b0;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      lock_q <= 1'b0;
      startup_q <= STARTUP_RST;
      fast_cnt_q <= 3'h0;
      auto_cnt_q <= 32'h0;
    end else begin
      lock_q <= lock_d;
      startup_q <= startup_d;
      fast_cnt_q <= fast_cnt_d;
      auto_cnt_q <= auto_cnt_d;
    end
  end

  // Bridge output gating
  logic drive_en_q, drive_en_d;
  logic all_off, brake;
  mfps_bridge_t bridge_q, bridge_d;
  logic [PERIOD_W-1:0] period_q, period_d;

  assign all_off = pins.flt.uv | pins.flt.ot | ~pins.sleep_active | ~drive_en_q;
  assign brake = lock_q | pins.flt.ov | pins.flt.oc;

  always_comb begin
    period_d = meas_period;
    if (all_off) begin
      bridge_d = '{hs: 3'h0, ls: 3'h0};
    end else if (brake) begin
      bridge_d = '{hs: 3'h0, ls: 3'h7};
    end else begin
      bridge_d = '{hs: drive_hs_in, ls: drive_ls_in};
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      bridge_q <= '0;
      period_q <= '0;
    end else begin
      bridge_q <= bridge_d;
      period_q <= period_d;
    end
  end

  // Avalon-MM slave, one wait cycle per access
  logic wait_q, wait_d;
  logic [31:0] rdata_q, rdata_d;
  logic [EV_W-1:0] status_q, status_d, enable_q, enable_d, events;
  logic irq_q, irq_d;
  logic [31:0] be_mask;
  logic wr_go;

  assign be_mask = {{8{avs_byteenable_in[3]}}, {8{avs_byteenable_in[2]}},
    {8{avs_byteenable_in[1]}}, {8{avs_byteenable_in[0]}}};
  assign wr_go = avs_write_in & ~wait_q;
  assign events[EV_UV] = pins.flt.uv & ~flt_prev_q.uv;
  assign events[EV_OV] = pins.flt.ov & ~flt_prev_q.ov;
  assign events[EV_OC] = pins.flt.oc & ~flt_prev_q.oc;
  assign events[EV_OT] = pins.flt.ot & ~flt_prev_q.ot;
  assign events[EV_LOCK] = lock_set;
  assign events[EV_UNLOCK] = lock_clr;

  always_comb begin
    wait_d = ~((avs_read_in | avs_write_in) & wait_q);
    drive_en_d = drive_en_q;
    enable_d = enable_q;
    status_d = status_q;
    rdata_d = rdata_q;
    if (wr_go && avs_address_in == REG_CTRL && avs_byteenable_in[0]) begin
      drive_en_d = avs_writedata_in[0];
    end
    if (wr_go && avs_address_in == REG_ENABLE) begin
      enable_d = (enable_q & ~be_mask[EV_W-1:0]) | (avs_writedata_in[EV_W-1:0] & be_mask[EV_W-1:0]);
    end
    if (wr_go && avs_address_in == REG_CLEAR) begin
      status_d = status_q & ~(avs_writedata_in[EV_W-1:0] & be_mask[EV_W-1:0]);
    end
    status_d = status_d | events;
    if (avs_read_in && wait_q) begin
      case (avs_address_in)
        REG_CTRL: rdata_d = {31'h0, drive_en_q};
        REG_STATUS: rdata_d = {26'h0, status_q};
        REG_ENABLE: rdata_d = {26'h0, enable_q};
        REG_STATE: rdata_d = {24'h0, pins.sleep_active, pins.standby, startup_q, lock_q,
          pins.flt.ot, pins.flt.oc, pins.flt.ov, pins.flt.uv};
        REG_PERIOD: rdata_d = period_q;
        default: rdata_d = 32'h0;
      endcase
    end
    irq_d = |(status_d & enable_d);
  end

  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      wait_q <= 1'b1;
      rdata_q <= 32'h0;
      drive_en_q <= CTRL_DRIVE_RST;
      enable_q <= ENABLE_RST;
      status_q <= '0;
      irq_q <= 1'b0;
    end else begin
      wait_q <= wait_d;
      rdata_q <= rdata_d;
      drive_en_q <= drive_en_d;
      enable_q <= enable_d;
      status_q <= status_d;
      irq_q <= irq_d;
    end
  end

  assign avs_readdata_out = rdata_q;
  assign avs_waitrequest_out = wait_q;
  assign hs_on_out = bridge_q.hs;
  assign ls_on_out = bridge_q.ls;
  assign lock_out = lock_q;
  assign startup_mode_out = startup_q;
  assign energize_period_out = period_q;
  assign irq_out = irq_q;

  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (sys_rst_in);

  lock_set_a: assert property (stalled && can_lock && !lock_q && !sleep_rise |=> lock_q)
    else $error("lock not declared after stall");
  auto_rel_a: assert property (lock_q && !pins.standby && auto_cnt_q == AUTO_LIM - 32'h1 |=> !lock_q)
    else $error("lock not cancelled after auto time");
  fast_rel_a: assert property (lock_q && hall_fast && fast_cnt_q == FAST_CYCLES - 3'h1 |=> !lock_q)
    else $error("lock not released by fast cycles");
  sleep_rel_a: assert property (sleep_rise |=> !lock_q && startup_q)
    else $error("wake did not release lock");
  lock_brake_a: assert property (lock_q && !all_off |=> hs_on_out == 3'h0 && ls_on_out == 3'h7)
    else $error("lock brake pattern wrong");
  uv_off_a: assert property (pins.flt.uv |=> hs_on_out == 3'h0 && ls_on_out == 3'h0)
    else $error("undervoltage did not turn all off");
  ov_brake_a: assert property (pins.flt.ov && !all_off |=> hs_on_out == 3'h0 && ls_on_out == 3'h7)
    else $error("overvoltage brake pattern wrong");
  oc_release_a: assert property (!all_off && !brake |=> hs_on_out == $past(drive_hs_in))
    else $error("drive not restored after faults clear");
  ot_off_a: assert property (pins.flt.ot && brake |=> ls_on_out == 3'h0)
    else $error("over-temperature did not win over brake");
  startup_a: assert property (pins.standby && stalled |=> startup_q)
    else $error("start-up not re-entered on standby");
  ot_all_off_a: assert property (pins.flt.ot |=> hs_on_out == 3'h0 && ls_on_out == 3'h0)
    else $error("over-temperature did not turn all off");
  oc_brake_a: assert property (pins.flt.oc && !all_off |=> hs_on_out == 3'h0 && ls_on_out == 3'h7)
    else $error("overcurrent brake pattern wrong");
  oc_clear_a: assert property (!brake && !all_off |=> ls_on_out == $past(drive_ls_in))
    else $error("low sides not restored after overcurrent");
  uv_wins_a: assert property (pins.flt.uv && brake |=> ls_on_out == 3'h0)
    else $error("undervoltage did not win over brake");
  stby_hold_a: assert property (lock_q && pins.standby && !sleep_rise && !fast_release |=> lock_q)
    else $error("lock cancelled during standby");
  no_early_lock_a: assert property (!lock_q && !stalled |=> !lock_q)
    else $error("lock declared without stall");
endmodule
`default_nettype wire

// ---- verilog/mfps_pkg.sv ----
/*
  Package for the motor fault protection sequencer: register map, field
  positions, reset values, timing constants and carrier structs.
  Assumes a 100 MHz system clock.
*/
`default_nettype none
package mfps_pkg;
  localparam int CLK_FREQ_HZ = 100000000;
  localparam int LOCK_TIME_MS = 500;
  localparam int AUTO_TIME_MS = 5000;
  localparam int LOCK_CYC = LOCK_TIME_MS * (CLK_FREQ_HZ / 1000);
  localparam int AUTO_CYC = AUTO_TIME_MS * (CLK_FREQ_HZ / 1000);
  localparam logic [2:0] FAST_CYCLES = 3'h5;
  localparam int PERIOD_W = 32;
  localparam int PIN_W = 7;

  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_CLEAR = 8'h08;
  localparam logic [7:0] REG_ENABLE = 8'h0C;
  localparam logic [7:0] REG_STATE = 8'h10;
  localparam logic [7:0] REG_PERIOD = 8'h14;

  localparam int EV_W = 6;
  localparam int EV_UV = 0;
  localparam int EV_OV = 1;
  localparam int EV_OC = 2;
  localparam int EV_OT = 3;
  localparam int EV_LOCK = 4;
  localparam int EV_UNLOCK = 5;

  localparam logic CTRL_DRIVE_RST = 1'b1;
  localparam logic [EV_W-1:0] ENABLE_RST = 6'h00;
  localparam logic STARTUP_RST = 1'b1;

  typedef struct packed {
    logic uv;
    logic ov;
    logic oc;
    logic ot;
  } mfps_fault_t;

  typedef struct packed {
    logic hall;
    logic sleep_active;
    logic standby;
    mfps_fault_t flt;
  } mfps_pins_t;

  typedef struct packed {
    logic [2:0] hs;
    logic [2:0] ls;
  } mfps_bridge_t;
endpackage
`default_nettype wire

// ---- verilog/mfps_sync.sv ----
/*
  Two flip-flop synchroniser bank, one stage pair per bit.
  Assumes asynchronous pin levels on sig_in.
*/
`timescale 1ns/1ps
`default_nettype none
module mfps_sync import mfps_pkg::*; #(
  parameter int W = PIN_W
) (
  input wire logic clk_sys_in,
  input wire logic sys_rst_in,
  input wire logic [W-1:0] sig_in,
  output logic [W-1:0] sig_out
);
  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      always_ff @(posedge clk_sys_in) begin
        if (sys_rst_in) begin
          meta_q[i] <= 1'b0;
          sync_q[i] <= 1'b0;
        end else begin
          meta_q[i] <= sig_in[i];
          sync_q[i] <= meta_q[i];
        end
      end
    end
  endgenerate

  assign sig_out = sync_q;
endmodule
`default_nettype wire

// ---- verilog/mfps_period_timer.sv ----
/*
  Position sensor period timer: rising edge detect, saturating cycle count,
  last full period capture, stall and fast-edge flags.
  Assumes a synchronised sensor level on the system clock.
*/
`timescale 1ns/1ps
`default_nettype none
module mfps_period_timer import mfps_pkg::*; #(
  parameter int unsigned LIMIT = LOCK_CYC
) (
  input wire logic clk_sys_in,
  input wire logic sys_rst_in,
  input wire logic hall_in,
  output logic edge_out,
  output logic fast_out,
  output logic stalled_out,
  output logic [PERIOD_W-1:0] period_out
);
  localparam logic [PERIOD_W-1:0] LIM = PERIOD_W'(LIMIT);
  logic prev_q, prev_d;
  logic [PERIOD_W-1:0] cnt_q, cnt_d;
  logic [PERIOD_W-1:0] last_q, last_d;

  assign edge_out = hall_in & ~prev_q;
  assign stalled_out = (cnt_q >= LIM - 1'b1);
  assign fast_out = edge_out & (cnt_q < LIM - 1'b1);
  assign period_out = last_q;

  always_comb begin
    prev_d = hall_in;
    cnt_d = cnt_q;
    last_d = last_q;
    if (edge_out) begin
      last_d = cnt_q + 1'b1;
      cnt_d = '0;
    end else if (cnt_q < LIM) begin
      cnt_d = cnt_q + 1'b1;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      prev_q <= 1'b0;
      cnt_q <= '0;
      last_q <= '0;
    end else begin
      prev_q <= prev_d;
      cnt_q <= cnt_d;
      last_q <= last_d;
    end
  end

  period_cap_a: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    edge_out |=> last_q == $past(cnt_q) + 1'b1)
    else $error("period not captured at sensor edge");
endmodule
`default_nettype wire

// ---- test/mfps_sensor_model.sv ----
/*
  Position sensor model: square wave with a set half period while running.
  Assumes the bench clock; a stopped rotor holds its last level.
*/
`timescale 1ns/1ps
`default_nettype none
module mfps_sensor_model (
  input wire logic clk_sys_in,
  input wire logic run_in,
  input wire logic [15:0] half_in,
  output logic hall_out
);
  logic [15:0] cnt_q = 16'h0000;
  initial hall_out = 1'b0;
  always @(posedge clk_sys_in) begin
    if (!run_in) begin
      cnt_q <= 16'h0000;
    end else if (cnt_q + 16'h0001 >= half_in) begin
      cnt_q <= 16'h0000;
      hall_out <= ~hall_out;
    end else begin
      cnt_q <= cnt_q + 16'h0001;
    end
  end
endmodule
`default_nettype wire

// ---- test/mfps_top_test.sv ----
/*
  Self-checking bench for the protection sequencer: faults, lock, release,
  start-up, registers and interrupt. Assumes short lock and cancel counts.
*/
`timescale 1ns/1ps
`default_nettype none
module mfps_top_test;
  import mfps_pkg::*;
  localparam int LK = 100;
  localparam int AU = 1000;
  logic clk_sys_in = 1'b0;
  logic sys_rst_in = 1'b1;
  mfps_fault_t flt = '0;
  mfps_bridge_t drv = '0;
  logic [2:0] hs_o, ls_o;
  logic sleep = 1'b1, stby = 1'b0, run = 1'b0, hall;
  logic rd = 1'b0, wr = 1'b0, wait_r, lock, start, irq;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdat = 32'h0, rdat, per, en;
  logic [3:0] fc [6] = '{4'h8, 4'h4, 4'h2, 4'h1, 4'hC, 4'h3};
  int n_mismatch = 0, samples_checked = 0, i, n;
  logic [31:0] expq [$];

  always #5 clk_sys_in = ~clk_sys_in;

  mfps_sensor_model sensor (.clk_sys_in(clk_sys_in), .run_in(run), .half_in(16'h0014), .hall_out(hall));

  mfps_top #(.LOCK_CYCLES(LK), .AUTO_CYCLES(AU)) dut (
    .clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in), .hall_in(hall), .sleep_active_in(sleep),
    .speed_command_standby_in(stby), .undervoltage_lockout_in(flt.uv), .overvoltage_lockout_in(flt.ov),
    .current_sense_in(flt.oc), .over_temp_in(flt.ot), .drive_hs_in(drv.hs), .drive_ls_in(drv.ls),
    .avs_address_in(addr), .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wdat),
    .avs_byteenable_in(4'hF), .avs_readdata_out(rdat), .avs_waitrequest_out(wait_r),
    .hs_on_out(hs_o), .ls_on_out(ls_o), .lock_out(lock), .startup_mode_out(start),
    .energize_period_out(per), .irq_out(irq));

  task automatic complete_run();
    $display("mismatches %0d checks %0d", n_mismatch, samples_checked);
    if (n_mismatch == 0 && samples_checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic fail(input string m);
    n_mismatch++;
    $display("CHECK FAILED %0t %s", $time, m);
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    samples_checked++;
    if (got !== exp) fail(m);
  endtask

  task automatic chk1(input logic got, input logic exp, input string m);
    chk({31'h0, got}, {31'h0, exp}, m);
  endtask

  task automatic br(input logic [2:0] h, input logic [2:0] l);
    chk({26'h0, hs_o, ls_o}, {26'h0, h, l}, "bridge outputs");
  endtask

  task automatic tick(input int c);
    repeat (c) @(posedge clk_sys_in);
  endtask

  // One Avalon transfer, held until waitrequest is seen low
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge clk_sys_in);
    rd <= !w;
    wr <= w;
    addr <= a;
    wdat <= d;
    for (k = 0; k < 50; k++) begin
      @(posedge clk_sys_in);
      if (wait_r === 1'b0) break;
    end
    if (k == 50) begin
      fail("bus timeout");
      complete_run();
    end
    rd <= 1'b0;
    wr <= 1'b0;
  endtask

  task automatic rd_exp(input logic [7:0] a, input logic [31:0] e);
    expq.push_back(e);
    bus(1'b0, a, 32'h0);
  endtask

  task automatic wait_lock(input logic v, input int lim, output int c);
    for (c = 0; c < lim; c++) begin
      @(posedge clk_sys_in);
      if (lock === v) break;
    end
    if (c == lim) begin
      fail("lock wait");
      complete_run();
    end
  endtask

  // Read results compared against the oldest note
  always @(posedge clk_sys_in) begin
    if (rd === 1'b1 && wait_r === 1'b0) begin
      if (expq.size() == 0) fail("unexpected read");
      else chk(rdat, expq.pop_front(), "read data");
    end
  end

  initial begin
    repeat (100000) @(posedge clk_sys_in);
    fail("run timeout");
    complete_run();
  end

  initial begin
    void'($urandom(32'hB2F9));
    tick(20);
    sys_rst_in <= 1'b0;
    run <= 1'b1;
    drv <= {3'($urandom()) | 3'h1, 3'($urandom())};
    rd_exp(REG_CTRL, 32'h1);
    rd_exp(REG_ENABLE, 32'h0);
    bus(1'b1, 8'h40, 32'hFFFFFFFF);
    rd_exp(8'h40, 32'h0);
    tick(400);
    chk1(lock, 1'b0, "no lock at speed");
    chk1(start, 1'b0, "start-up left");
    chk(per, 32'h28, "period");
    rd_exp(REG_PERIOD, 32'h28);
    br(drv.hs, drv.ls);
    for (i = 0; i < 6; i++) begin
      flt <= fc[i];
      tick(6);
      if (fc[i][3] | fc[i][0]) br(3'h0, 3'h0);
      else br(3'h0, 3'h7);
      flt <= '0;
      tick(6);
      br(drv.hs, drv.ls);
    end
    bus(1'b1, REG_CTRL, 32'h0);
    tick(3);
    br(3'h0, 3'h0);
    bus(1'b1, REG_CTRL, 32'h1);
    chk1(irq, 1'b0, "masked irq");
    rd_exp(REG_STATUS, 32'h0F);
    bus(1'b1, REG_CLEAR, 32'h3F);
    en = $urandom() & 32'h3F;
    bus(1'b1, REG_ENABLE, en);
    rd_exp(REG_ENABLE, en);
    bus(1'b1, REG_ENABLE, 32'h10);
    for (i = 0; i < 100 && hall !== 1'b0; i++) tick(1);
    for (n = 0; n < 100 && hall !== 1'b1; n++) tick(1);
    if (i == 100 || n == 100) begin
      fail("sensor wait");
      complete_run();
    end
    run <= 1'b0;
    wait_lock(1'b1, LK + 50, n);
    chk1(n >= LK - 2 && n <= LK + 5, 1'b1, "lock onset");
    tick(3);
    br(3'h0, 3'h7);
    chk1(irq, 1'b1, "lock irq");
    rd_exp(REG_STATE, 32'h90);
    rd_exp(REG_STATUS, 32'h10);
    bus(1'b1, REG_CLEAR, 32'h10);
    tick(2);
    chk1(irq, 1'b0, "irq cleared");
    run <= 1'b1;
    wait_lock(1'b0, 400, n);
    chk1(n >= 238 && n <= 248, 1'b1, "fast release");
    chk(per, 32'h28, "period after release");
    run <= 1'b0;
    wait_lock(1'b1, 200, n);
    stby <= 1'b1;
    tick(AU + 200);
    chk1(lock, 1'b1, "held in standby");
    chk1(start, 1'b1, "start-up on standby");
    stby <= 1'b0;
    wait_lock(1'b0, AU + 100, n);
    chk1(n >= AU - 5 && n <= AU + 10, 1'b1, "auto cancel");
    wait_lock(1'b1, 200, n);
    // Sleep toggled only with the rotor stopped
    sleep <= 1'b0;
    tick(6);
    br(3'h0, 3'h0);
    sleep <= 1'b1;
    wait_lock(1'b0, 8, n);
    tick(2);
    chk1(start, 1'b1, "start-up on wake");
    wait_lock(1'b1, 200, n);
    sys_rst_in <= 1'b1;
    tick(2);
    sys_rst_in <= 1'b0;
    tick(1);
    chk1(lock, 1'b0, "power reapplied");
    complete_run();
  end
endmodule
`default_nettype wire
